// ---- rtl/crs_core.sv ----
// CPU core execution block: register file, ALU, program counter, return
// stack, I/O space access and status register.
// Assumes program memory answers the fetch address with the word one clock
// later, and I/O peripherals answer reads combinationally.
// Behaviour
// - Constant forms reach only registers 16..31
// - Other forms reach all 32 registers
// - Register 30 points for indirect register access
// - Read, compute, write back in one cycle
// - Nine-bit PC over 512 sixteen-bit words
// - I/O address from six instruction bits
// - Relative target is PC plus k plus one
// - Three-level nine-bit hardware return stack
// - Call pushes level 0, shifts deeper
// - Return pops level 0, shifts up
// - Deep nesting silently drops oldest address
// - Core runs on undivided input clock
// - Fetch overlaps execute, one per cycle
// - In moves I/O to register, out moves register to I/O
// - Bit operations only on I/O 0x00..0x1F
// - Bit set/clear rewrite whole I/O register
// - Global enable gates every interrupt
// - Interrupt clears, irq exit sets global enable
// - Copy flag stores transferred register bits
// - Nibble carry reports low-nibble carry
// - Sign bit always negative xor overflow
// - Flag bits 3..0 from ALU results
`timescale 1ns/1ns
module crs_core
    import crs_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    output logic [PC_W-1:0] PROG_ADDR,
    input wire logic [15:0] PROG_DATA,
    input wire logic IRQ_REQ,
    input wire logic [PC_W-1:0] IRQ_VECTOR,
    output logic IRQ_ACK,
    output logic [5:0] IO_ADDR,
    output logic [7:0] IO_WDATA,
    output logic IO_WR,
    output logic IO_RD,
    input wire logic [7:0] IO_RDATA,
    output logic [7:0] STATUS_FLAGS
);
    typedef struct packed {
        logic [REG_CNT-1:0][7:0] gpr;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
        logic [PC_W-1:0] pc;
        logic [7:0] stat;
        logic flush;
    } crs_state_t;

    crs_state_t st_reg;
    crs_state_t st_next;
    crs_op_t op;

    function automatic logic [7:0] flags(input logic [7:0] old, input logic [7:0] res,
                                         input logic c, input logic v, input logic h,
                                         input logic keep_z, input logic upd_ch);
        logic [7:0] f;
        f = old;
        f[SF_BELOW] = res[7];
        f[SF_OFLO] = v;
        f[SF_NULL] = keep_z ? (old[SF_NULL] & (res == 8'h00)) : (res == 8'h00);
        if (upd_ch) begin
            f[SF_CARRY] = c;
            f[SF_NIBBLE_C] = h;
        end
        f[SF_NEG_XOR] = f[SF_BELOW] ^ f[SF_OFLO];
        return f;
    endfunction : flags

    crs_decode u_dec (
        .instr(PROG_DATA),
        .op(op)
    );

    // Constant forms carry only four register bits
    function automatic logic const_form(input crs_op_t o);
        return o == OP_LOAD_K || o == OP_SUB_K || o == OP_SBC_K || o == OP_CP_K
            || o == OP_AND_K || o == OP_OR_K;
    endfunction : const_form

    function automatic logic bit_io_form(input crs_op_t o);
        return o == OP_BIT_SET || o == OP_BIT_CLR || o == OP_SKIP_HIGH || o == OP_SKIP_LOW;
    endfunction : bit_io_form

    // Two's complement overflow of an 8-bit add or subtract
    function automatic logic ovf_of(input logic sub, input logic sa, input logic sb,
                                    input logic sr);
        return sub ? ((sa ^ sb) & (sa ^ sr)) : (~(sa ^ sb) & (sa ^ sr));
    endfunction : ovf_of

    // One clock, no divider: every state element advances on CORE_CLK
    logic [15:0] iw;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [4:0] rdi;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] kk;
    logic [7:0] res;
    logic [8:0] sum;
    logic [4:0] hsum;
    logic [5:0] ioa;
    logic [2:0] bit_sel;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_skip;
    logic [PC_W-1:0] rel_tgt;
    logic take_irq, subtract, use_carry, is_logic, wr_rd, io_bit_val;

    always_comb begin
        iw = PROG_DATA;
        st_next = st_reg;
        rd = iw[8:4];
        rdi = {1'b1, iw[7:4]};
        rr = {iw[9], iw[3:0]};
        kk = {iw[11:8], iw[3:0]};
        ioa = {iw[10:9], iw[3:0]};
        if (bit_io_form(op)) begin
            ioa = {1'b0, iw[7:3]};
        end
        bit_sel = iw[2:0];
        pc_inc = st_reg.pc + 9'h001;
        // A taken skip steps over one word, never over a pair
        pc_skip = st_reg.pc + 9'h002;
        rel_tgt = st_reg.pc + iw[PC_W-1:0] + 9'h001;
        take_irq = IRQ_REQ && st_reg.stat[SF_GLOB_EN] && !st_reg.flush;
        a = st_reg.gpr[rd];
        b = st_reg.gpr[rr];
        subtract = 1'b0;
        use_carry = 1'b0;
        is_logic = 1'b0;
        wr_rd = 1'b0;
        case (op)
            OP_LOAD_K, OP_SUB_K, OP_SBC_K, OP_CP_K, OP_AND_K, OP_OR_K: begin
                a = st_reg.gpr[rdi];
                b = kk;
            end
            default: begin
            end
        endcase
        subtract = (op == OP_SUB || op == OP_SBC || op == OP_CP || op == OP_SUB_K
                    || op == OP_SBC_K || op == OP_CP_K);
        use_carry = (op == OP_ADC || op == OP_SBC || op == OP_SBC_K);
        if (subtract) begin
            sum = {1'b0, a} - {1'b0, b} - {8'h00, use_carry & st_reg.stat[SF_CARRY]};
            hsum = {1'b0, a[3:0]} - {1'b0, b[3:0]}
                   - {4'h0, use_carry & st_reg.stat[SF_CARRY]};
        end else begin
            sum = {1'b0, a} + {1'b0, b} + {8'h00, use_carry & st_reg.stat[SF_CARRY]};
            hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]}
                   + {4'h0, use_carry & st_reg.stat[SF_CARRY]};
        end
        res = sum[7:0];
        io_bit_val = IO_RDATA[bit_sel];

        IO_ADDR = ioa;
        IO_WDATA = 8'h00;
        IO_WR = 1'b0;
        IO_RD = 1'b0;
        IRQ_ACK = 1'b0;
        st_next.flush = 1'b0;
        st_next.pc = pc_inc;

        if (st_reg.flush) begin
            // Word in hand is not the one to run; fetch the held address again
            // so the target executes in the next cycle
            st_next.pc = st_reg.pc;
        end else if (take_irq) begin
            // Interrupted word is not executed; it runs again after return
            IRQ_ACK = 1'b1;
            st_next.stk = {st_reg.stk[1:0], st_reg.pc};
            st_next.stat[SF_GLOB_EN] = 1'b0;
            st_next.pc = IRQ_VECTOR;
            st_next.flush = 1'b1;
        end else begin
            case (op)
                OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_SUB_K, OP_SBC_K: begin
                    wr_rd = 1'b1;
                    st_next.stat = flags(st_reg.stat, res, sum[8],
                        ovf_of(subtract, a[7], b[7], res[7]),
                        hsum[4], use_carry && subtract, 1'b1);
                end
                OP_CP, OP_CP_K: begin
                    st_next.stat = flags(st_reg.stat, res, sum[8],
                        ovf_of(1'b1, a[7], b[7], res[7]), hsum[4], 1'b0, 1'b1);
                end
                OP_AND, OP_AND_K, OP_OR, OP_OR_K, OP_EOR: begin
                    is_logic = 1'b1;
                    wr_rd = 1'b1;
                    res = (op == OP_AND || op == OP_AND_K) ? (a & b)
                        : (op == OP_EOR) ? (a ^ b) : (a | b);
                    st_next.stat = flags(st_reg.stat, res, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
                end
                OP_INC, OP_DEC: begin
                    wr_rd = 1'b1;
                    res = (op == OP_INC) ? a + 8'h01 : a - 8'h01;
                    st_next.stat = flags(st_reg.stat, res, 1'b0,
                        (op == OP_INC) ? (res == 8'h80) : (res == 8'h7f),
                        1'b0, 1'b0, 1'b0);
                end
                OP_MOV: begin
                    wr_rd = 1'b1;
                    res = b;
                end
                OP_LOAD_K: begin
                    wr_rd = 1'b1;
                    res = kk;
                end
                OP_LDZ: begin
                    wr_rd = 1'b1;
                    res = st_reg.gpr[st_reg.gpr[POINTER_REG_IDX][4:0]];
                end
                OP_STZ: begin
                    st_next.gpr[st_reg.gpr[POINTER_REG_IDX][4:0]] = a;
                end
                OP_IN: begin
                    // Status lives here; IO_ADDR still shows its address, but no IO_RD strobe reaches the bus
                    wr_rd = 1'b1;
                    IO_RD = (ioa != IO_STATUS_ADDR);
                    res = (ioa == IO_STATUS_ADDR) ? st_reg.stat : IO_RDATA;
                end
                OP_OUT: begin
                    if (ioa == IO_STATUS_ADDR) begin
                        st_next.stat = a;
                        st_next.stat[SF_NEG_XOR] = a[SF_BELOW] ^ a[SF_OFLO];
                    end else begin
                        IO_WR = 1'b1;
                        IO_WDATA = a;
                    end
                end
                OP_BIT_SET, OP_BIT_CLR: begin
                    // Whole byte is written back, so set W1C flags get cleared
                    IO_RD = 1'b1;
                    IO_WR = 1'b1;
                    IO_WDATA = IO_RDATA;
                    IO_WDATA[bit_sel] = (op == OP_BIT_SET);
                end
                OP_SKIP_HIGH, OP_SKIP_LOW: begin
                    IO_RD = 1'b1;
                    if (io_bit_val == (op == OP_SKIP_HIGH)) begin
                        st_next.pc = pc_skip;
                        st_next.flush = 1'b1;
                    end
                end
                OP_BIT_STORE: begin
                    st_next.stat[SF_COPY_BOOL] = a[bit_sel];
                end
                OP_BIT_LOAD: begin
                    wr_rd = 1'b1;
                    res = a;
                    res[bit_sel] = st_reg.stat[SF_COPY_BOOL];
                end
                OP_RJMP: begin
                    st_next.pc = rel_tgt;
                    st_next.flush = 1'b1;
                end
                OP_REL_CALL: begin
                    st_next.stk = {st_reg.stk[1:0], pc_inc};
                    st_next.pc = rel_tgt;
                    st_next.flush = 1'b1;
                end
                OP_SUB_EXIT, OP_IRQ_EXIT: begin
                    // Deepest level is copied up, so an extra return reuses it
                    st_next.pc = st_reg.stk[0];
                    st_next.stk = {st_reg.stk[2], st_reg.stk[2:1]};
                    st_next.flush = 1'b1;
                    if (op == OP_IRQ_EXIT) begin
                        st_next.stat[SF_GLOB_EN] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            if (wr_rd) begin
                if (const_form(op)) begin
                    st_next.gpr[rdi] = res;
                end else begin
                    st_next.gpr[rd] = res;
                end
            end
        end
        PROG_ADDR = st_next.pc;
        STATUS_FLAGS = st_reg.stat;
    end

    // Reset leaves flush set, so the first cycle only fetches address zero
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_reg.gpr <= '0;
            st_reg.stk <= '0;
            st_reg.pc <= PC_RESET;
            st_reg.stat <= STATUS_RESET;
            st_reg.flush <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : crs_core

// ---- rtl/crs_decode.sv ----
// Instruction decoder: maps a 16-bit instruction word onto an operation code.
// Assumes the word is stable for the whole execute cycle.
`timescale 1ns/1ns
module crs_decode
    import crs_pkg::*;
(
    input wire logic [15:0] instr,
    output crs_op_t op
);
    always_comb begin
        op = OP_NOP;
        case (instr[15:12])
            4'h0: begin
                case (instr[11:10])
                    2'h1: op = OP_CP;
                    2'h2: op = OP_SBC;
                    2'h3: op = OP_ADD;
                    default: op = (instr[9:0] == 10'h000) ? OP_NOP : OP_NOP;
                endcase
            end
            4'h1: begin
                case (instr[11:10])
                    2'h1: op = OP_CP;
                    2'h2: op = OP_SUB;
                    2'h3: op = OP_ADC;
                    default: op = OP_NOP;
                endcase
            end
            4'h2: begin
                case (instr[11:10])
                    2'h0: op = OP_AND;
                    2'h1: op = OP_EOR;
                    2'h2: op = OP_OR;
                    default: op = OP_MOV;
                endcase
            end
            4'h3: op = OP_CP_K;
            4'h4: op = OP_SBC_K;
            4'h5: op = OP_SUB_K;
            4'h6: op = OP_OR_K;
            4'h7: op = OP_AND_K;
            4'h8: op = instr[9] ? OP_STZ : OP_LDZ;
            4'h9: begin
                if (instr[11:8] == 4'h8) begin
                    op = OP_BIT_CLR;
                end else if (instr[11:8] == 4'h9) begin
                    op = OP_SKIP_LOW;
                end else if (instr[11:8] == 4'ha) begin
                    op = OP_BIT_SET;
                end else if (instr[11:8] == 4'hb) begin
                    op = OP_SKIP_HIGH;
                end else if (instr == 16'h9508) begin
                    op = OP_SUB_EXIT;
                end else if (instr == 16'h9518) begin
                    op = OP_IRQ_EXIT;
                end else if (instr[11:9] == 3'h2 && instr[3:0] == 4'h3) begin
                    op = OP_INC;
                end else if (instr[11:9] == 3'h2 && instr[3:0] == 4'ha) begin
                    op = OP_DEC;
                end else begin
                    op = OP_NOP;
                end
            end
            4'hb: op = instr[11] ? OP_OUT : OP_IN;
            4'hc: op = OP_RJMP;
            4'hd: op = OP_REL_CALL;
            4'he: op = OP_LOAD_K;
            4'hf: op = instr[11] ? (instr[9] ? OP_NOP : OP_BIT_STORE) : OP_BIT_LOAD;
            default: op = OP_NOP;
        endcase
    end
endmodule : crs_decode

// ---- rtl/crs_pkg.sv ----
// Package for the CPU core execution block: status register layout, I/O map,
// operation code list and stack depth.
// Assumes a single undivided system clock and 16-bit instruction words.
package crs_pkg;
    localparam int PC_W = 9;
    localparam int STACK_DEPTH = 3;
    localparam int REG_CNT = 32;
    localparam logic [5:0] IO_STATUS_ADDR = 6'h3f;
    localparam logic [5:0] IO_BIT_MAX = 6'h1f;
    localparam logic [4:0] POINTER_REG_IDX = 5'h1e;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 9'h000;
    localparam int SF_GLOB_EN = 7;
    localparam int SF_COPY_BOOL = 6;
    localparam int SF_NIBBLE_C = 5;
    localparam int SF_NEG_XOR = 4;
    localparam int SF_OFLO = 3;
    localparam int SF_BELOW = 2;
    localparam int SF_NULL = 1;
    localparam int SF_CARRY = 0;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_SBC = 5'h04, OP_CP = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
        OP_EOR = 5'h08, OP_MOV = 5'h09, OP_LOAD_K = 5'h0a, OP_SUB_K = 5'h0b,
        OP_SBC_K = 5'h0c, OP_CP_K = 5'h0d, OP_AND_K = 5'h0e, OP_OR_K = 5'h0f,
        OP_IN = 5'h10, OP_OUT = 5'h11, OP_BIT_SET = 5'h12, OP_BIT_CLR = 5'h13,
        OP_SKIP_HIGH = 5'h14, OP_SKIP_LOW = 5'h15, OP_BIT_STORE = 5'h16, OP_BIT_LOAD = 5'h17,
        OP_RJMP = 5'h18, OP_REL_CALL = 5'h19, OP_SUB_EXIT = 5'h1a, OP_IRQ_EXIT = 5'h1b,
        OP_LDZ = 5'h1c, OP_STZ = 5'h1d, OP_INC = 5'h1e, OP_DEC = 5'h1f
    } crs_op_t;
endpackage : crs_pkg

// ---- test/crs_core_properties.sv ----
// Checker for the core: interrupt gating, status layout and bit access.
// Assumes it is bound to the core and sees only its ports.
`timescale 1ns/1ns
module crs_core_properties
    import crs_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic IRQ_REQ,
    input wire logic IRQ_ACK,
    input wire logic [5:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_RDATA,
    input wire logic [7:0] STATUS_FLAGS
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    AST_IRQ_GATED: assert property (IRQ_ACK |-> STATUS_FLAGS[SF_GLOB_EN] && IRQ_REQ)
        else $error("interrupt taken while gated off");
    AST_IRQ_PROMPT: assert property
        (IRQ_REQ && STATUS_FLAGS[SF_GLOB_EN] |-> ##[0:2] (IRQ_ACK || !IRQ_REQ))
        else $error("enabled interrupt not taken");
    AST_IRQ_CLEARS: assert property (IRQ_ACK |=> !STATUS_FLAGS[SF_GLOB_EN])
        else $error("global enable kept after interrupt");
    AST_ACK_ONE: assert property (IRQ_ACK |=> !IRQ_ACK)
        else $error("interrupt taken in flush cycle");
    AST_GLOB_FALL: assert property ($fell(STATUS_FLAGS[SF_GLOB_EN]) |->
        $past(IRQ_ACK) || $past(IO_ADDR) == IO_STATUS_ADDR)
        else $error("global enable dropped without cause");
    AST_SIGN_XOR: assert property
        (STATUS_FLAGS[SF_NEG_XOR] == (STATUS_FLAGS[SF_BELOW] ^ STATUS_FLAGS[SF_OFLO]))
        else $error("sign flag not negative xor overflow");
    AST_BIT_RANGE: assert property (IO_WR && IO_RD |-> IO_ADDR <= IO_BIT_MAX)
        else $error("bit access above low I/O range");
    AST_BIT_ONE: assert property
        (IO_WR && IO_RD |-> $countones(IO_WDATA ^ IO_RDATA) <= 1)
        else $error("bit access changed more than one bit");
    AST_STATUS_RESET: assert property ($fell(RST) |-> STATUS_FLAGS == STATUS_RESET)
        else $error("status not cleared by reset");
endmodule : crs_core_properties

// ---- test/crs_partner.sv ----
// Program memory and I/O space model facing the core.
// Assumes the bench loads both arrays before reset is released.
`timescale 1ns/1ns
module crs_partner
    import crs_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic [PC_W-1:0] PROG_ADDR,
    output logic [15:0] PROG_DATA,
    input wire logic [5:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    output logic [7:0] IO_RDATA
);
    logic [15:0] prog_mem [512];
    logic [7:0] io_mem [64];
    // Unread lines show the inverse so stale data cannot pass
    assign IO_RDATA = IO_RD ? io_mem[IO_ADDR] : ~io_mem[IO_ADDR];
    always @(posedge CORE_CLK) begin
        PROG_DATA <= prog_mem[PROG_ADDR];
        if (IO_WR) begin
            io_mem[IO_ADDR] <= IO_WDATA;
        end
    end
endmodule : crs_partner

// ---- test/tb_crs_core.sv ----
// Bench for the core: runs a small program and checks every I/O write.
// Assumes the partner model holds program memory and the I/O space.
`timescale 1ns/1ns
module tb_crs_core
    import crs_pkg::*;
;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic IRQ_REQ = 1'b1;
    logic [PC_W-1:0] IRQ_VECTOR = 9'h100;
    logic [PC_W-1:0] PROG_ADDR;
    logic [15:0] PROG_DATA;
    logic IRQ_ACK, IO_WR, IO_RD;
    logic [5:0] IO_ADDR;
    logic [7:0] IO_WDATA, IO_RDATA, STATUS_FLAGS, k1, k2, k3, k4;
    logic [13:0] expect_q [$];
    int fails = 0;
    int tests_run = 0;
    int seed = 81;
    always #20 CORE_CLK = ~CORE_CLK;
    crs_core u_crs_core (.CORE_CLK(CORE_CLK), .RST(RST), .PROG_ADDR(PROG_ADDR),
        .PROG_DATA(PROG_DATA), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACK(IRQ_ACK),
        .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD),
        .IO_RDATA(IO_RDATA), .STATUS_FLAGS(STATUS_FLAGS));
    crs_partner u_crs_partner (.CORE_CLK(CORE_CLK), .PROG_ADDR(PROG_ADDR),
        .PROG_DATA(PROG_DATA), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR),
        .IO_RD(IO_RD), .IO_RDATA(IO_RDATA));
    function automatic logic [15:0] load_k(input int d, input logic [7:0] k);
        return 16'he000 | 16'(k[7:4]) << 8 | 16'(d - 16) << 4 | 16'(k[3:0]);
    endfunction : load_k
    function automatic logic [15:0] io(input logic [15:0] b, input logic [5:0] a, input int r);
        return b | 16'(a[5:4]) << 9 | 16'(r) << 4 | 16'(a[3:0]);
    endfunction : io
    task automatic put(input int a, input logic [15:0] w);
        u_crs_partner.prog_mem[a] = w;
    endtask : put
    task automatic note(input logic [5:0] a, input logic [7:0] d);
        expect_q.push_back({a, d});
    endtask : note
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    task automatic complete_run;
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // Status writes stay inside the core, so they are not compared here
    always @(posedge CORE_CLK) begin
        if (!RST && IO_WR === 1'b1 && IO_ADDR !== IO_STATUS_ADDR) begin
            if (expect_q.size() == 0) begin
                check("unexpected write", 8'h01, 8'h00);
            end else begin
                check("io address", {2'b00, IO_ADDR}, {2'b00, expect_q[0][13:8]});
                check("io data", IO_WDATA, expect_q[0][7:0]);
                void'(expect_q.pop_front());
            end
        end
        if (IRQ_ACK === 1'b1) begin
            IRQ_REQ <= 1'b0;
        end
    end
    initial begin
        k1 = 8'($random(seed));
        k2 = 8'($random(seed));
        k3 = 8'($random(seed));
        k4 = 8'($random(seed));
        for (int i = 0; i < 512; i++) begin
            put(i, 16'h0000);
        end
        u_crs_partner.io_mem[5] = k2;
        u_crs_partner.io_mem[6] = k3;
        u_crs_partner.io_mem[7] = k4;
        put(0, load_k(16, k1));
        put(1, io(16'hb800, 6'h10, 16));
        note(6'h10, k1);
        put(2, load_k(31, 8'h80));
        put(3, load_k(17, 8'h80));
        put(4, 16'h0ff1);
        put(5, io(16'hb800, 6'h11, 31));
        note(6'h11, 8'h00);
        put(6, io(16'hb000, 6'h3f, 20));
        put(7, io(16'hb800, 6'h12, 20));
        note(6'h12, 8'h1b);
        // Four nested calls with wrapping targets; the oldest return is lost
        put(8, 16'hdff0);
        put(9'h1f9, 16'hd026);
        put(9'h1fa, io(16'hb800, 6'h14, 16));
        put(9'h1fb, 16'hc00d);
        put(9'h020, 16'hd00f);
        put(9'h021, io(16'hb800, 6'h15, 16));
        put(9'h022, 16'h9508);
        put(9'h030, 16'hd00f);
        put(9'h031, io(16'hb800, 6'h17, 16));
        put(9'h032, 16'h9508);
        put(9'h040, io(16'hb800, 6'h16, 16));
        put(9'h041, 16'h9508);
        note(6'h16, k1);
        note(6'h17, k1);
        note(6'h15, k1);
        note(6'h14, k1);
        put(9, load_k(16, 8'h80));
        put(10, io(16'hb800, 6'h3f, 16));
        // Handler touches no flag, so status needs no save here
        put(9'h100, io(16'hb000, 6'h3f, 20));
        put(9'h101, io(16'hb800, 6'h18, 20));
        put(9'h102, 16'h9518);
        note(6'h18, 8'h00);
        put(11, io(16'hb000, 6'h3f, 21));
        put(12, io(16'hb800, 6'h19, 21));
        note(6'h19, 8'h80);
        put(13, 16'h9a2b);
        note(6'h05, k2 | 8'h08);
        put(14, 16'h9830);
        note(6'h06, k3 & 8'hfe);
        put(15, io(16'hb000, 6'h07, 22));
        put(16, io(16'hb800, 6'h1a, 22));
        note(6'h1a, k4);
        put(17, load_k(30, 8'h05));
        put(18, 16'h8360);
        put(19, 16'h8170);
        put(20, io(16'hb800, 6'h1b, 23));
        note(6'h1b, k4);
        // Both skips are taken; a write to 0x1c would pair with the wrong note
        put(21, 16'h9b2b);
        put(22, io(16'hb800, 6'h1c, 16));
        put(23, io(16'hb800, 6'h1d, 22));
        note(6'h1d, k4);
        put(24, 16'h9930);
        put(25, io(16'hb800, 6'h1c, 16));
        put(26, io(16'hb800, 6'h1e, 22));
        note(6'h1e, k4);
        put(27, 16'hcfff);
        repeat (6) @(posedge CORE_CLK);
        RST <= 1'b0;
        for (int n = 0; n < 400 && expect_q.size() > 0; n++) begin
            @(posedge CORE_CLK);
        end
        if (expect_q.size() > 0) begin
            fails++;
        end
        repeat (4) @(posedge CORE_CLK);
        complete_run();
    end
endmodule : tb_crs_core
bind crs_core crs_core_properties u_crs_core_properties (.CORE_CLK(CORE_CLK), .RST(RST),
    .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
    .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA), .STATUS_FLAGS(STATUS_FLAGS));
